/* logic/fade_stage.sv */
// One channel of the soft-mute fade: sample times gain, registered.
// Assumes gain never exceeds unity, so the product cannot overflow.
`timescale 1ns/100ps
module fade_stage #(
   parameter int SAMPLE_W = 24
) (
   input  wire logic                                clk_i,
   input  wire logic                                srst_i,
   input  wire logic        [SAMPLE_W-1:0]          sample_i,
   input  wire logic        [audio_port_pkg::GAIN_W-1:0] gain_i,
   output logic             [SAMPLE_W-1:0]          sample_o
);
   logic signed [SAMPLE_W+audio_port_pkg::GAIN_W:0] prod;

   always_comb begin
      prod = $signed(sample_i) * $signed({1'b0, gain_i});
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sample_o <= '0;
      end else begin
         sample_o <= prod[audio_port_pkg::GAIN_SHIFT +: SAMPLE_W];
      end
   end
endmodule // fade_stage

/* logic/four_channel_serial_audio_port.sv */
// Four-channel serial audio port: two stereo input lines, register file,
// fade stage, frame FIFO and two stereo output lines.
// Assumes the far party drives both bit clocks and word selects, and keeps
// both bit clocks running while srst_i is held.
//
// Overview of operation
// - Each direction uses two data lines, one bit clock and one word select.
// - Word select low marks the left slot and high marks the right slot.
// - Samples are two's complement and travel most significant bit first.
// - The left MSB comes one bit clock after word select falls.
// - The sender changes data on the falling bit clock edge; the receiver samples on the rising edge.
// - Four channels arrive on two input data lines, one stereo pair per line.
// - Each sample period four samples are gathered and written into the register file.
// - Processing reads the register file and writes its results back to it.
// - Output samples come from the register file through the fade stage to the output block.
// - Capture, processing and output repeat once per incoming sample period.
// - Input and output ports each have their own bit clock and word select.
`timescale 1ns/100ps
module four_channel_serial_audio_port #(
   parameter int SAMPLE_W = audio_port_pkg::SAMPLE_W_DEF
) (
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   input  wire logic soft_mute_i,
   input  wire logic in_bit_clock_i,
   input  wire logic in_word_select_i,
   input  wire logic in_data_line_a_i,
   input  wire logic in_data_line_b_i,
   input  wire logic out_bit_clock_i,
   input  wire logic out_word_select_i,
   output logic      out_data_line_a_o,
   output logic      out_data_line_b_o,
   output logic      overrun_o,
   output logic      muted_o
);
   localparam int FRAME_W = audio_port_pkg::CHANNELS * SAMPLE_W;
   localparam int CNT_W   = $clog2(SAMPLE_W + 1);

   // ------------------------------------------------------------
   // Input link domain: receiver on in_bit_clock
   // ------------------------------------------------------------
   logic               in_rst_s1_r;
   logic               in_rst_s2_r;
   logic               in_ws_prev_r;
   logic [SAMPLE_W-1:0] in_sh_a_r;
   logic [SAMPLE_W-1:0] in_sh_b_r;
   logic [CNT_W-1:0]    in_cnt_r;
   logic [SAMPLE_W-1:0] in_left_a_r;
   logic [SAMPLE_W-1:0] in_left_b_r;
   logic [FRAME_W-1:0]  in_frame_r;
   logic                in_tgl_r;
   logic [SAMPLE_W-1:0] in_sh_a_nxt;
   logic [SAMPLE_W-1:0] in_sh_b_nxt;
   logic [CNT_W-1:0]    in_cnt_nxt;
   logic [SAMPLE_W-1:0] in_word_a;
   logic [SAMPLE_W-1:0] in_word_b;

   // Reset reaches the link domain through its own synchroniser
   always_ff @(posedge in_bit_clock_i) begin
      in_rst_s1_r <= srst_i;
      in_rst_s2_r <= in_rst_s1_r;
   end

   // Extra bits past the sample width are dropped, short words are left aligned
   always_comb begin
      if (in_cnt_r < CNT_W'(SAMPLE_W)) begin
         in_sh_a_nxt = {in_sh_a_r[SAMPLE_W-2:0], in_data_line_a_i};
         in_sh_b_nxt = {in_sh_b_r[SAMPLE_W-2:0], in_data_line_b_i};
         in_cnt_nxt  = in_cnt_r + 1'b1;
      end else begin
         in_sh_a_nxt = in_sh_a_r;
         in_sh_b_nxt = in_sh_b_r;
         in_cnt_nxt  = in_cnt_r;
      end
      in_word_a = in_sh_a_nxt << (CNT_W'(SAMPLE_W) - in_cnt_nxt);
      in_word_b = in_sh_b_nxt << (CNT_W'(SAMPLE_W) - in_cnt_nxt);
   end

   // Word select is sampled with the data on the rising edge; a change
   // means this bit is the LSB of the slot just ending
   always_ff @(posedge in_bit_clock_i) begin
      if (in_rst_s2_r) begin
         in_ws_prev_r <= audio_port_pkg::WS_RIGHT;
         in_sh_a_r    <= '0;
         in_sh_b_r    <= '0;
         in_cnt_r     <= '0;
         in_left_a_r  <= '0;
         in_left_b_r  <= '0;
         in_frame_r   <= '0;
         in_tgl_r     <= 1'b0;
      end else begin
         in_ws_prev_r <= in_word_select_i;
         if (in_word_select_i != in_ws_prev_r) begin
            in_sh_a_r <= '0;
            in_sh_b_r <= '0;
            in_cnt_r  <= '0;
            if (in_ws_prev_r == audio_port_pkg::WS_LEFT) begin
               in_left_a_r <= in_word_a;
               in_left_b_r <= in_word_b;
            end else begin
               in_frame_r[audio_port_pkg::CH_FL*SAMPLE_W +: SAMPLE_W] <= in_left_a_r;
               in_frame_r[audio_port_pkg::CH_FR*SAMPLE_W +: SAMPLE_W] <= in_word_a;
               in_frame_r[audio_port_pkg::CH_RL*SAMPLE_W +: SAMPLE_W] <= in_left_b_r;
               in_frame_r[audio_port_pkg::CH_RR*SAMPLE_W +: SAMPLE_W] <= in_word_b;
               in_tgl_r <= ~in_tgl_r;
            end
         end else begin
            in_sh_a_r <= in_sh_a_nxt;
            in_sh_b_r <= in_sh_b_nxt;
            in_cnt_r  <= in_cnt_nxt;
         end
      end
   end

   // ------------------------------------------------------------
   // Core domain: frame arrival
   // ------------------------------------------------------------
   logic in_tgl_s1_r;
   logic in_tgl_s2_r;
   logic in_tgl_s3_r;
   logic mute_s1_r;
   logic mute_s2_r;
   logic frame_arrived;

   // Frame word is held a full frame after its toggle, so it is safe to read
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         in_tgl_s1_r <= 1'b0;
         in_tgl_s2_r <= 1'b0;
         in_tgl_s3_r <= 1'b0;
         mute_s1_r   <= 1'b0;
         mute_s2_r   <= 1'b0;
      end else begin
         in_tgl_s1_r <= in_tgl_r;
         in_tgl_s2_r <= in_tgl_s1_r;
         in_tgl_s3_r <= in_tgl_s2_r;
         mute_s1_r   <= soft_mute_i;
         mute_s2_r   <= mute_s1_r;
      end
   end

   assign frame_arrived = in_tgl_s2_r != in_tgl_s3_r;

   // ------------------------------------------------------------
   // Core domain: register file, fade and sequencer
   // ------------------------------------------------------------
   audio_port_pkg::proc_state_t state_r;
   logic [SAMPLE_W-1:0]               regfile_r [audio_port_pkg::CHANNELS];
   logic [SAMPLE_W-1:0]               faded     [audio_port_pkg::CHANNELS];
   logic [audio_port_pkg::GAIN_W-1:0] gain_r;
   logic [FRAME_W-1:0]                push_data;
   logic                              push_valid;
   logic                              push_ready;
   logic                              proc_late_r;

   for (genvar ch = 0; ch < audio_port_pkg::CHANNELS; ch++) begin : g_fade
      fade_stage #(
         .SAMPLE_W (SAMPLE_W)
      ) u_fade (
         .clk_i    (ref_clk_i),
         .srst_i   (srst_i),
         .sample_i (regfile_r[ch]),
         .gain_i   (gain_r),
         .sample_o (faded[ch])
      );
      assign push_data[ch*SAMPLE_W +: SAMPLE_W] = regfile_r[ch];
   end

   assign push_valid = (state_r == audio_port_pkg::ST_PUSH);

   // Register file holds raw samples, then the faded results
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         for (int ch = 0; ch < audio_port_pkg::CHANNELS; ch++) begin
            regfile_r[ch] <= '0;
         end
      end else if (state_r == audio_port_pkg::ST_IDLE && frame_arrived) begin
         for (int ch = 0; ch < audio_port_pkg::CHANNELS; ch++) begin
            regfile_r[ch] <= in_frame_r[ch*SAMPLE_W +: SAMPLE_W];
         end
      end else if (state_r == audio_port_pkg::ST_PROC && proc_late_r) begin
         for (int ch = 0; ch < audio_port_pkg::CHANNELS; ch++) begin
            regfile_r[ch] <= faded[ch];
         end
      end
   end

   // Second cycle of ST_PROC: only now does the fade register hold the new raw frame
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         proc_late_r <= 1'b0;
      end else begin
         proc_late_r <= (state_r == audio_port_pkg::ST_PROC) && !proc_late_r;
      end
   end

   // ST_PROC lasts two cycles so the registered fade output is ready
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_r <= audio_port_pkg::ST_IDLE;
      end else begin
         case (state_r)
            audio_port_pkg::ST_IDLE: begin
               if (frame_arrived) begin
                  state_r <= audio_port_pkg::ST_PROC;
               end
            end
            audio_port_pkg::ST_PROC: begin
               if (proc_late_r) begin
                  state_r <= audio_port_pkg::ST_PUSH;
               end
            end
            audio_port_pkg::ST_PUSH: begin
               if (push_ready) begin
                  state_r <= audio_port_pkg::ST_IDLE;
               end
            end
            default: begin
               state_r <= audio_port_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Frames that arrive while the previous one is still in ST_PROC or ST_PUSH are lost
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         overrun_o <= 1'b0;
      end else begin
         overrun_o <= frame_arrived && (state_r != audio_port_pkg::ST_IDLE);
      end
   end

   // One gain step per frame; starting at zero gives a soft demute after reset
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         gain_r  <= audio_port_pkg::GAIN_RESET;
         muted_o <= 1'b1;
      end else begin
         if (state_r == audio_port_pkg::ST_PROC && proc_late_r) begin
            if (mute_s2_r && gain_r != '0) begin
               gain_r <= gain_r - audio_port_pkg::GAIN_STEP;
            end else if (!mute_s2_r && gain_r != audio_port_pkg::GAIN_UNITY) begin
               gain_r <= gain_r + audio_port_pkg::GAIN_STEP;
            end
         end
         muted_o <= (gain_r == '0);
      end
   end

   // ------------------------------------------------------------
   // Frame FIFO and hand-over to the output domain
   // ------------------------------------------------------------
   logic               fifo_valid;
   logic [FRAME_W-1:0] fifo_data;
   logic [FRAME_W-1:0] out_frame_r;
   logic               out_tgl_r;
   logic               out_ack_s1_r;
   logic               out_ack_s2_r;
   logic               out_busy;
   logic               out_ack_r;

   frame_fifo #(
      .WIDTH (FRAME_W),
      .DEPTH (audio_port_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (ref_clk_i),
      .srst_i      (srst_i),
      .in_valid_i  (push_valid),
      .in_ready_o  (push_ready),
      .in_data_i   (push_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (!out_busy),
      .out_data_o  (fifo_data)
   );

   assign out_busy = out_tgl_r != out_ack_s2_r;

   // Toggle handshake: out_frame_r stays put until the output side acks
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         out_ack_s1_r <= 1'b0;
         out_ack_s2_r <= 1'b0;
         out_tgl_r    <= 1'b0;
         out_frame_r  <= '0;
      end else begin
         out_ack_s1_r <= out_ack_r;
         out_ack_s2_r <= out_ack_s1_r;
         if (fifo_valid && !out_busy) begin
            out_frame_r <= fifo_data;
            out_tgl_r   <= ~out_tgl_r;
         end
      end
   end

   // ------------------------------------------------------------
   // Output link domain: transmitter on falling out_bit_clock
   // ------------------------------------------------------------
   logic               out_rst_s1_r;
   logic               out_rst_s2_r;
   logic               out_tgl_s1_r;
   logic               out_tgl_s2_r;
   logic [FRAME_W-1:0] out_hold_r;
   logic               out_ws_prev_r;
   logic [SAMPLE_W-1:0] out_sh_a_r;
   logic [SAMPLE_W-1:0] out_sh_b_r;

   always_ff @(negedge out_bit_clock_i) begin
      out_rst_s1_r <= srst_i;
      out_rst_s2_r <= out_rst_s1_r;
   end

   // Without a fresh frame the last one repeats rather than glitching to zero
   always_ff @(negedge out_bit_clock_i) begin
      if (out_rst_s2_r) begin
         out_tgl_s1_r <= 1'b0;
         out_tgl_s2_r <= 1'b0;
         out_ack_r    <= 1'b0;
         out_hold_r   <= '0;
      end else begin
         out_tgl_s1_r <= out_tgl_r;
         out_tgl_s2_r <= out_tgl_s1_r;
         if (out_tgl_s2_r != out_ack_r) begin
            out_hold_r <= out_frame_r;
            out_ack_r  <= out_tgl_s2_r;
         end
      end
   end

   // A change seen at this falling edge happened one bit ago: send the MSB now
   always_ff @(negedge out_bit_clock_i) begin
      if (out_rst_s2_r) begin
         out_ws_prev_r     <= audio_port_pkg::WS_RIGHT;
         out_sh_a_r        <= '0;
         out_sh_b_r        <= '0;
         out_data_line_a_o <= 1'b0;
         out_data_line_b_o <= 1'b0;
      end else begin
         out_ws_prev_r <= out_word_select_i;
         if (out_word_select_i != out_ws_prev_r) begin
            if (out_word_select_i == audio_port_pkg::WS_LEFT) begin
               out_data_line_a_o <= out_hold_r[audio_port_pkg::CH_FL*SAMPLE_W + SAMPLE_W - 1];
               out_data_line_b_o <= out_hold_r[audio_port_pkg::CH_RL*SAMPLE_W + SAMPLE_W - 1];
               out_sh_a_r <= out_hold_r[audio_port_pkg::CH_FL*SAMPLE_W +: SAMPLE_W] << 1;
               out_sh_b_r <= out_hold_r[audio_port_pkg::CH_RL*SAMPLE_W +: SAMPLE_W] << 1;
            end else begin
               out_data_line_a_o <= out_hold_r[audio_port_pkg::CH_FR*SAMPLE_W + SAMPLE_W - 1];
               out_data_line_b_o <= out_hold_r[audio_port_pkg::CH_RR*SAMPLE_W + SAMPLE_W - 1];
               out_sh_a_r <= out_hold_r[audio_port_pkg::CH_FR*SAMPLE_W +: SAMPLE_W] << 1;
               out_sh_b_r <= out_hold_r[audio_port_pkg::CH_RR*SAMPLE_W +: SAMPLE_W] << 1;
            end
         end else begin
            // Bits past the sample width go out as zero
            out_data_line_a_o <= out_sh_a_r[SAMPLE_W-1];
            out_data_line_b_o <= out_sh_b_r[SAMPLE_W-1];
            out_sh_a_r        <= out_sh_a_r << 1;
            out_sh_b_r        <= out_sh_b_r << 1;
         end
      end
   end
endmodule // four_channel_serial_audio_port

/* logic/frame_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock and reset.
`timescale 1ns/100ps
module frame_fifo #(
   parameter int WIDTH = 96,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count_r != DEPTH[AW:0]);
   assign out_valid_o = (count_r != '0);
   assign out_data_o  = mem_r[rd_ptr_r];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule // frame_fifo

/* pkg/audio_port_pkg.sv */
// Constants and types shared by the four-channel serial audio port.
// Assumes a single reference clock domain plus two externally timed bit clocks.
package audio_port_pkg;

   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam int SAMPLE_W_DEF = 24;
   localparam int CHANNELS     = 4;
   localparam int CH_FL        = 0;
   localparam int CH_FR        = 1;
   localparam int CH_RL        = 2;
   localparam int CH_RR        = 3;
   localparam int FIFO_DEPTH   = 8;

   // ------------------------------------------------------------
   // Slot coding of word select
   // ------------------------------------------------------------
   localparam logic WS_LEFT  = 1'h0;
   localparam logic WS_RIGHT = 1'h1;

   // ------------------------------------------------------------
   // Fade gain, unity is 1 << GAIN_SHIFT
   // ------------------------------------------------------------
   localparam int          GAIN_W     = 9;
   localparam int          GAIN_SHIFT = 8;
   localparam logic [8:0]  GAIN_UNITY = 9'h100;
   localparam logic [8:0]  GAIN_STEP  = 9'h001;
   localparam logic [8:0]  GAIN_RESET = 9'h000;

   // ------------------------------------------------------------
   // Processing sequencer
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PROC = 2'b01,
      ST_PUSH = 2'b10
   } proc_state_t;

endpackage

/* testbench/audio_link_model.sv */
// Far-side audio source and sink: makes both bit clocks and word selects,
// sends one stereo pair per input line and collects what the port returns.
// Assumes 32-bit slots; the bench sets the four words to send.
`timescale 1ns/100ps
module audio_link_model (
   output logic             in_bck_o,
   output logic             in_ws_o,
   output logic             in_da_o,
   output logic             in_db_o,
   output logic             out_bck_o,
   output logic             out_ws_o,
   input  wire logic        out_da_i,
   input  wire logic        out_db_i,
   input  wire logic [31:0] tx_i [4],
   output logic      [31:0] rx_o [4],
   output int               rx_cnt_o
);
   logic [5:0]  ib_r = 6'h3f;
   logic [5:0]  ob_r = 6'h3f;
   logic [63:0] sa_r;
   logic [63:0] sb_r;
   int          cnt_r = 0;
   assign rx_cnt_o = cnt_r;
   // Low for the left slot; falls on the last right bit, one bit before the left MSB
   function automatic logic ws_of(input logic [5:0] b);
      return (b >= 6'h1f) && (b != 6'h3f);
   endfunction
   function automatic logic bit_of(input logic [31:0] l, input logic [31:0] r, input logic [5:0] b);
      return b[5] ? r[~b[4:0]] : l[~b[4:0]];
   endfunction
   // Both clocks run free, also through reset, which the port needs for its synchronisers
   initial begin
      in_bck_o = 1'b0;
      forever #3 in_bck_o = ~in_bck_o;
   end
   initial begin
      out_bck_o = 1'b0;
      #1.3;
      forever #3 out_bck_o = ~out_bck_o;
   end
   always @(negedge in_bck_o) begin
      ib_r <= ib_r + 6'h01;
      in_ws_o <= ws_of(ib_r + 6'h01);
      in_da_o <= bit_of(tx_i[0], tx_i[1], ib_r + 6'h01);
      in_db_o <= bit_of(tx_i[2], tx_i[3], ib_r + 6'h01);
   end
   always @(negedge out_bck_o) begin
      ob_r <= ob_r + 6'h01;
      out_ws_o <= ws_of(ob_r + 6'h01);
   end
   always @(posedge out_bck_o) begin
      sa_r = {sa_r[62:0], out_da_i};
      sb_r = {sb_r[62:0], out_db_i};
      if (ob_r == 6'h3f) begin
         rx_o[0] <= sa_r[63:32];
         rx_o[1] <= sa_r[31:0];
         rx_o[2] <= sb_r[63:32];
         rx_o[3] <= sb_r[31:0];
         cnt_r <= cnt_r + 1;
      end
   end
endmodule // audio_link_model

/* testbench/audio_port_chk.sv */
// Concurrent checks on the pins of the four-channel serial audio port.
// Assumes both bit clocks keep running through reset.
`timescale 1ns/100ps
module audio_port_chk (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic soft_mute_i,
   input wire logic out_bit_clock_i,
   input wire logic out_word_select_i,
   input wire logic out_data_line_a_o,
   input wire logic out_data_line_b_o,
   input wire logic overrun_o,
   input wire logic muted_o
);
   logic [5:0] slot_bit_r;
   logic       ws_prev_r;
   logic       a_hi_r;
   logic       b_hi_r;
   // ------------------------------------------------------------
   // Output slot tracking
   // ------------------------------------------------------------
   // Bit index within the slot, counted as the port itself sees word select
   always_ff @(negedge out_bit_clock_i) begin
      ws_prev_r <= out_word_select_i;
      if (srst_i || out_word_select_i != ws_prev_r) begin
         slot_bit_r <= 6'h00;
      end else if (slot_bit_r != 6'h3f) begin
         slot_bit_r <= slot_bit_r + 6'h01;
      end
   end
   always_ff @(posedge out_bit_clock_i) begin
      a_hi_r <= out_data_line_a_o;
      b_hi_r <= out_data_line_b_o;
   end
   property p_reset_muted;
      @(posedge ref_clk_i) disable iff (srst_i) $fell(srst_i) |-> muted_o;
   endproperty
   a_reset_muted: assert property (p_reset_muted) else $error("gain not zero after reset");
   property p_reset_no_overrun;
      @(posedge ref_clk_i) disable iff (srst_i) $fell(srst_i) |-> !overrun_o ##1 !overrun_o;
   endproperty
   a_reset_no_overrun: assert property (p_reset_no_overrun) else $error("overrun right after reset");
   property p_mute_rise;
      @(posedge ref_clk_i) disable iff (srst_i) $rose(muted_o) |-> soft_mute_i && $past(soft_mute_i, 4);
   endproperty
   a_mute_rise: assert property (p_mute_rise) else $error("silenced without a mute request");
   property p_mute_fall;
      @(posedge ref_clk_i) disable iff (srst_i) $fell(muted_o) |-> !$past(soft_mute_i, 4);
   endproperty
   a_mute_fall: assert property (p_mute_fall) else $error("gain rose while mute held");
   property p_mute_hold;
      @(posedge ref_clk_i) disable iff (srst_i) muted_o && soft_mute_i && $past(soft_mute_i, 4) |=> muted_o;
   endproperty
   a_mute_hold: assert property (p_mute_hold) else $error("gain left zero under mute");
   property p_fade_soft;
      @(posedge ref_clk_i) disable iff (srst_i) $rose(soft_mute_i) && !muted_o |-> !muted_o [*8];
   endproperty
   a_fade_soft: assert property (p_fade_soft) else $error("mute was abrupt");
   property p_bit_on_fall;
      @(negedge out_bit_clock_i) disable iff (srst_i)
         out_data_line_a_o == a_hi_r && out_data_line_b_o == b_hi_r;
   endproperty
   a_bit_on_fall: assert property (p_bit_on_fall) else $error("output data moved on rising edge");
   property p_pad_zero;
      @(negedge out_bit_clock_i) disable iff (srst_i)
         slot_bit_r >= 6'h18 |-> !out_data_line_a_o && !out_data_line_b_o;
   endproperty
   a_pad_zero: assert property (p_pad_zero) else $error("bit past sample width not zero");
   c_unmute: cover property (@(posedge ref_clk_i) disable iff (srst_i) $fell(muted_o));
   c_mute: cover property (@(posedge ref_clk_i) disable iff (srst_i) $rose(muted_o));
   c_msb_one: cover property (@(negedge out_bit_clock_i) disable iff (srst_i) slot_bit_r == 6'h00 && out_data_line_a_o);
endmodule // audio_port_chk

bind four_channel_serial_audio_port audio_port_chk u_chk (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .soft_mute_i(soft_mute_i), .out_bit_clock_i(out_bit_clock_i),
   .out_word_select_i(out_word_select_i), .out_data_line_a_o(out_data_line_a_o),
   .out_data_line_b_o(out_data_line_b_o), .overrun_o(overrun_o), .muted_o(muted_o));

/* testbench/four_channel_serial_audio_port_bench.sv */
// Self-checking bench for the four-channel serial audio port.
// Assumes the link model makes both bit clocks at a 6 ns period.
`timescale 1ns/100ps
module four_channel_serial_audio_port_bench;
   localparam int SW = audio_port_pkg::SAMPLE_W_DEF;
   localparam logic [31:0] CORNER [4] = '{32'h80000000, 32'h7fffff00, 32'hffffffff, 32'h000001ff};
   logic        ref_clk_i, srst_i, soft_mute_i;
   logic        in_bck, in_ws, in_da, in_db, out_bck, out_ws, out_da, out_db, overrun, muted;
   logic [31:0] tx [4];
   logic [31:0] rx [4];
   logic [31:0] seed;
   int          rx_cnt, error_cnt, n_tests, ovr_cnt;
   four_channel_serial_audio_port u_dut (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .soft_mute_i(soft_mute_i), .in_bit_clock_i(in_bck),
      .in_word_select_i(in_ws), .in_data_line_a_i(in_da), .in_data_line_b_i(in_db),
      .out_bit_clock_i(out_bck), .out_word_select_i(out_ws), .out_data_line_a_o(out_da),
      .out_data_line_b_o(out_db), .overrun_o(overrun), .muted_o(muted));
   audio_link_model u_link (
      .in_bck_o(in_bck), .in_ws_o(in_ws), .in_da_o(in_da), .in_db_o(in_db), .out_bck_o(out_bck),
      .out_ws_o(out_ws), .out_da_i(out_da), .out_db_i(out_db), .tx_i(tx), .rx_o(rx), .rx_cnt_o(rx_cnt));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   // Low bits beyond the sample width are dropped on entry and sent as zero
   function automatic logic [31:0] expect_word(input logic [31:0] w, input logic on);
      return on ? (w >> (32 - SW)) << (32 - SW) : 32'h0;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_frames(input int n);
      int stop;
      stop = rx_cnt + n;
      repeat (n * 40) begin
         @(posedge ref_clk_i);
         if (rx_cnt >= stop) break;
      end
      if (rx_cnt < stop) begin
         error_cnt++;
         $display("MISMATCH t=%0t frame wait ran out", $time);
      end
      #1;
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, watchdog and sequence
   // ------------------------------------------------------------
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   // Equal-rate link clocks leave the sequencer idle at every arrival, so no frame may drop
   always @(posedge ref_clk_i) begin
      if (overrun === 1'b1) ovr_cnt <= ovr_cnt + 1;
   end
   // About 1000 frames of some 16 cycles each are expected
   initial begin
      #(30000 * 25);
      error_cnt++;
      close_out();
   end
   initial begin
      srst_i = 1'b1;
      soft_mute_i = 1'b0;
      seed = 32'h00000031;
      for (int k = 0; k < 4; k++) tx[k] = 32'h0;
      repeat (4) @(posedge ref_clk_i);
      #1;
      check({31'h0, muted}, 32'h1);
      srst_i = 1'b0;
      wait_frames(300);
      check({31'h0, muted}, 32'h0);
      // Distinct words per channel expose swapped lines or slots
      for (int i = 0; i < 12; i++) begin
         for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            tx[k] = (i < 4) ? CORNER[(i + k) % 4] : seed;
         end
         wait_frames(5);
         for (int k = 0; k < 4; k++) check(rx[k], expect_word(tx[k], 1'b1));
      end
      soft_mute_i = 1'b1;
      wait_frames(300);
      check({31'h0, muted}, 32'h1);
      for (int k = 0; k < 4; k++) check(rx[k], 32'h0);
      soft_mute_i = 1'b0;
      wait_frames(300);
      for (int k = 0; k < 4; k++) check(rx[k], expect_word(tx[k], 1'b1));
      check(ovr_cnt, 32'h0);
      close_out();
   end
endmodule // four_channel_serial_audio_port_bench
